//--- design/eir_ext_irq.sv
`timescale 1ns/1ps
module eir_ext_irq (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  // sfr access from the cpu
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  // pins and internal events
  input wire logic wake_pin_in,
  input wire logic second_wake_pin_in,
  input wire logic usb_resume_in,
  input wire logic ext_six_pin_in,
  input wire logic ext_four_pin_in,
  input wire logic ext_five_pin_n_in,
  input wire logic waveform_engine_irq_in,
  // flags held in the base flag register
  input wire logic usb_irq_flag_in,
  input wire logic twowire_irq_flag_in,
  input wire logic ext_four_request_in,
  input wire logic ext_five_request_in,
  input wire logic global_enable_in,
  // set pulses toward the base flag register
  output logic ext_four_set_out,
  output logic ext_five_set_out,
  // to serial port 1 and the cpu sequencer
  output logic serial1_baud_doubler_out,
  output logic [5:0] pending_out,
  output logic irq_req_out,
  output logic [2:0] irq_src_out,
  output logic [1:0] irq_level_out
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // lowest set slot is the highest natural
  // priority; returns none when vec is empty
  function automatic eir_pkg::eir_sel_t
      first_slot(input logic [eir_pkg::NSRC-1:0] vec);
    eir_pkg::eir_sel_t sel;
    sel = eir_pkg::EIR_SEL_NONE;
    for (int i = eir_pkg::NSRC - 1; i >= 0; i--) begin
      if (vec[i]) begin
        sel = eir_pkg::eir_sel_t'(3'(i));
      end
    end
    return sel;
  endfunction : first_slot

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic serial1_baud_doubler;
  logic wake_irq_enable;
  logic wake_flag;
  logic ext_six_flag;
  logic [eir_pkg::NSRC-1:0] ext_irq_enable;
  logic [eir_pkg::NSRC-1:0] ext_irq_priority;
  logic fifo_prev;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic wr_control;
  logic wr_enable;
  logic wr_priority;

  // a write is only taken while clocks run
  assign wr_control = ce_in && sfr_wr_in &&
                      (sfr_addr_in == eir_pkg::ADDR_CONTROL);
  assign wr_enable = ce_in && sfr_wr_in &&
                     (sfr_addr_in == eir_pkg::ADDR_ENABLE);
  assign wr_priority = ce_in && sfr_wr_in &&
                       (sfr_addr_in == eir_pkg::ADDR_PRIORITY);

  // ----------------------------------------
  // pin edge detection
  // ----------------------------------------
  eir_edge_if #(.N(eir_pkg::NEDGE)) edges ();

  // pin five is active low, so it enters
  // inverted and every lane looks for a rise
  always_comb begin
    edges.level = '0;
    edges.level[eir_pkg::EDG_WAKE] = wake_pin_in;
    edges.level[eir_pkg::EDG_WAKE2] = second_wake_pin_in;
    edges.level[eir_pkg::EDG_SIX] = ext_six_pin_in;
    edges.level[eir_pkg::EDG_FOUR] = ext_four_pin_in;
    edges.level[eir_pkg::EDG_FIVE] = ~ext_five_pin_n_in;
  end

  eir_edge_det u_edge (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .edges(edges)
  );

  logic wake_event;
  logic six_event;
  logic four_event;
  logic five_event;
  logic fifo_event;

  // fifo source is a level; only its rise
  // counts, as the shared slot is edge-only
  assign fifo_event = waveform_engine_irq_in & ~fifo_prev;
  assign wake_event = edges.rise[eir_pkg::EDG_WAKE] |
                      edges.rise[eir_pkg::EDG_WAKE2] |
                      usb_resume_in;
  assign six_event = edges.rise[eir_pkg::EDG_SIX];
  assign four_event = edges.rise[eir_pkg::EDG_FOUR] | fifo_event;
  assign five_event = edges.rise[eir_pkg::EDG_FIVE];

  // fifo source history
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      fifo_prev <= 1'b0;
    end else if (ce_in) begin
      fifo_prev <= waveform_engine_irq_in;
    end
  end

  // ----------------------------------------
  // set pulses for flags four and five
  // ----------------------------------------
  // those flags live in the base register;
  // this block only reports the edges
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ext_four_set_out <= eir_pkg::RST_BIT;
      ext_five_set_out <= eir_pkg::RST_BIT;
    end else if (ce_in) begin
      ext_four_set_out <= four_event;
      ext_five_set_out <= five_event;
    end
  end

  // ----------------------------------------
  // control register, plain bits
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      serial1_baud_doubler <= eir_pkg::RST_BIT;
      wake_irq_enable <= eir_pkg::RST_BIT;
    end else if (wr_control) begin
      serial1_baud_doubler <= sfr_wdata_in[eir_pkg::CTL_DOUBLER];
      wake_irq_enable <= sfr_wdata_in[eir_pkg::CTL_WAKE_EN];
    end
  end

  // ----------------------------------------
  // wake flag
  // ----------------------------------------
  // hardware set wins over a write of zero
  // in the same cycle, so no wake is lost
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wake_flag <= eir_pkg::RST_BIT;
    end else if (ce_in) begin
      if (wake_event) begin
        wake_flag <= 1'b1;
      end else if (wr_control) begin
        wake_flag <= sfr_wdata_in[eir_pkg::CTL_WAKE_FLAG];
      end
    end
  end

  // ----------------------------------------
  // external six flag
  // ----------------------------------------
  // sticky until software writes zero
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ext_six_flag <= eir_pkg::RST_BIT;
    end else if (ce_in) begin
      if (six_event) begin
        ext_six_flag <= 1'b1;
      end else if (wr_control) begin
        ext_six_flag <= sfr_wdata_in[eir_pkg::CTL_SIX_FLAG];
      end
    end
  end

  // ----------------------------------------
  // enable and priority registers
  // ----------------------------------------
  // upper three bits are not stored
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ext_irq_enable <= eir_pkg::RST_ENABLE;
    end else if (wr_enable) begin
      ext_irq_enable <= sfr_wdata_in[eir_pkg::NSRC-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ext_irq_priority <= eir_pkg::RST_PRIORITY;
    end else if (wr_priority) begin
      ext_irq_priority <= sfr_wdata_in[eir_pkg::NSRC-1:0];
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] next_rdata;

  // reserved fields are constants, never
  // storage, so they cannot be disturbed
  always_comb begin
    next_rdata = eir_pkg::RST_RDATA;
    unique case (sfr_addr_in)
      eir_pkg::ADDR_CONTROL: begin
        next_rdata[eir_pkg::CTL_DOUBLER] = serial1_baud_doubler;
        next_rdata[eir_pkg::CTL_ONE] = 1'b1;
        next_rdata[eir_pkg::CTL_WAKE_EN] = wake_irq_enable;
        next_rdata[eir_pkg::CTL_WAKE_FLAG] = wake_flag;
        next_rdata[eir_pkg::CTL_SIX_FLAG] = ext_six_flag;
        next_rdata[2:0] = eir_pkg::RSVD_LOW;
      end
      eir_pkg::ADDR_ENABLE: begin
        next_rdata = {eir_pkg::RSVD_HIGH, ext_irq_enable};
      end
      eir_pkg::ADDR_PRIORITY: begin
        next_rdata = {eir_pkg::RSVD_HIGH, ext_irq_priority};
      end
      default: begin
        next_rdata = eir_pkg::RST_RDATA;
      end
    endcase
  end

  // data stands until the next read strobe
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sfr_rdata_out <= eir_pkg::RST_RDATA;
    end else if (ce_in && sfr_rd_in) begin
      sfr_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------
  // serial port 1 rate
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      serial1_baud_doubler_out <= eir_pkg::RST_BIT;
    end else if (ce_in) begin
      serial1_baud_doubler_out <= serial1_baud_doubler;
    end
  end

  // ----------------------------------------
  // pending requests
  // ----------------------------------------
  logic [eir_pkg::NSRC-1:0] raw;
  logic [eir_pkg::NSRC-1:0] pend;
  logic wake_pend;

  // the flag is a level, so a flag left set
  // at return keeps the request up
  always_comb begin
    raw = '0;
    raw[eir_pkg::SRC_USB] = usb_irq_flag_in;
    raw[eir_pkg::SRC_TWOWIRE] = twowire_irq_flag_in;
    raw[eir_pkg::SRC_FOUR] = ext_four_request_in;
    raw[eir_pkg::SRC_FIVE] = ext_five_request_in;
    raw[eir_pkg::SRC_SIX] = ext_six_flag;
  end

  // per-source gate, then the global gate
  // bit 0 usb, 1 two-wire, 2 four, 3 five,
  // 4 six: one mask serves all five
  assign pend = raw & ext_irq_enable &
                {eir_pkg::NSRC{global_enable_in}};

  // wake ignores the global enable
  assign wake_pend = wake_flag & wake_irq_enable;

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  logic [eir_pkg::NSRC-1:0] pend_high;
  logic [eir_pkg::NSRC-1:0] pend_low;
  eir_pkg::eir_sel_t next_src;
  eir_pkg::eir_lvl_t next_level;

  // priority bit 1 puts a source high
  assign pend_high = pend & ext_irq_priority;
  assign pend_low = pend & ~ext_irq_priority;

  // assigned level first, natural slot second;
  // wake always stands above both levels
  always_comb begin
    next_src = eir_pkg::EIR_SEL_NONE;
    next_level = eir_pkg::EIR_LVL_LOW;
    if (wake_pend) begin
      next_src = eir_pkg::EIR_SEL_WAKE;
      next_level = eir_pkg::EIR_LVL_TOP;
    end else if (|pend_high) begin
      next_src = first_slot(pend_high);
      next_level = eir_pkg::EIR_LVL_HIGH;
    end else if (|pend_low) begin
      next_src = first_slot(pend_low);
      next_level = eir_pkg::EIR_LVL_LOW;
    end
  end

  // ----------------------------------------
  // request outputs
  // ----------------------------------------
  // one cycle behind the flags; the cpu
  // samples per instruction, far slower
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pending_out <= '0;
      irq_req_out <= 1'b0;
      irq_src_out <= eir_pkg::EIR_SEL_NONE;
      irq_level_out <= eir_pkg::EIR_LVL_LOW;
    end else if (ce_in) begin
      pending_out <= {wake_pend, pend};
      irq_req_out <= wake_pend | (|pend);
      irq_src_out <= next_src;
      irq_level_out <= next_level;
    end
  end

endmodule : eir_ext_irq

//--- design/eir_pkg.sv
package eir_pkg;

  // ----------------------------------------
  // register addresses in the sfr space
  // ----------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'hD8;
  localparam logic [7:0] ADDR_ENABLE = 8'hE8;
  localparam logic [7:0] ADDR_PRIORITY = 8'hF8;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTL_DOUBLER = 7;
  localparam int CTL_ONE = 6;
  localparam int CTL_WAKE_EN = 5;
  localparam int CTL_WAKE_FLAG = 4;
  localparam int CTL_SIX_FLAG = 3;

  // ----------------------------------------
  // source slots, lower slot wins a tie
  // ----------------------------------------
  localparam int NSRC = 5;
  localparam int SRC_USB = 0;
  localparam int SRC_TWOWIRE = 1;
  localparam int SRC_FOUR = 2;
  localparam int SRC_FIVE = 3;
  localparam int SRC_SIX = 4;

  // reserved upper bits of enable and priority, reserved low bits of control
  localparam logic [2:0] RSVD_HIGH = 3'h7;
  localparam logic [2:0] RSVD_LOW = 3'h0;

  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [NSRC-1:0] RST_ENABLE = 5'h00;
  localparam logic [NSRC-1:0] RST_PRIORITY = 5'h00;
  localparam logic RST_BIT = 1'b0;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ----------------------------------------
  // edge detector lanes
  // ----------------------------------------
  localparam int NEDGE = 5;
  localparam int EDG_WAKE = 0;
  localparam int EDG_WAKE2 = 1;
  localparam int EDG_SIX = 2;
  localparam int EDG_FOUR = 3;
  localparam int EDG_FIVE = 4;

  // selected source code
  typedef enum logic [2:0] {
    EIR_SEL_USB = 3'h0,
    EIR_SEL_TWOWIRE = 3'h1,
    EIR_SEL_FOUR = 3'h2,
    EIR_SEL_FIVE = 3'h3,
    EIR_SEL_SIX = 3'h4,
    EIR_SEL_WAKE = 3'h5,
    EIR_SEL_NONE = 3'h7
  } eir_sel_t;

  // assigned level of the selected request
  typedef enum logic [1:0] {
    EIR_LVL_LOW = 2'h0,
    EIR_LVL_HIGH = 2'h1,
    EIR_LVL_TOP = 2'h2
  } eir_lvl_t;

endpackage : eir_pkg

//--- design/eir_edge_if.sv
`timescale 1ns/1ps
interface eir_edge_if #(
  parameter int N = 5
);
  logic [N-1:0] level;
  logic [N-1:0] rise;

  modport src (output level, input rise);
  modport det (input level, output rise);
endinterface : eir_edge_if

//--- design/eir_edge_det.sv
`timescale 1ns/1ps
module eir_edge_det (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  eir_edge_if.det edges
);

  // lane count follows the package, as the interface is sized from it
  localparam int N = eir_pkg::NEDGE;

  logic [N-1:0] prev;
  logic primed;

  // ----------------------------------------
  // previous sample per lane
  // ----------------------------------------
  // the first sample after reset only loads
  // prev, so a pin already high at release
  // does not look like a fresh edge
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      prev <= '0;
      primed <= 1'b0;
    end else if (ce_in) begin
      prev <= edges.level;
      primed <= 1'b1;
    end
  end

  // ----------------------------------------
  // inactive-to-active detection
  // ----------------------------------------
  always_comb begin
    edges.rise = primed ? (edges.level & ~prev) : '0;
  end

endmodule : eir_edge_det

//--- dv/eir_ext_irq_monitor.sv
`timescale 1ns/1ps
module eir_ext_irq_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic ext_four_pin_in,
  input wire logic ext_five_pin_n_in,
  input wire logic usb_irq_flag_in,
  input wire logic twowire_irq_flag_in,
  input wire logic global_enable_in,
  input wire logic ext_four_set_out,
  input wire logic ext_five_set_out,
  input wire logic serial1_baud_doubler_out,
  input wire logic [5:0] pending_out,
  input wire logic irq_req_out,
  input wire logic [2:0] irq_src_out,
  input wire logic [1:0] irq_level_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ----------------
  // events
  // ----------------
  sequence s_rd;
    ce_in && sfr_rd_in;
  endsequence
  sequence s_wr_ctl;
    ce_in && sfr_wr_in && (sfr_addr_in == eir_pkg::ADDR_CONTROL);
  endsequence
  // first sample after reset only primes the detector
  sequence s_four_rise;
    $past(rst_n_in, 2) && ce_in && $past(ce_in) && ext_four_pin_in && !$past(ext_four_pin_in);
  endsequence
  sequence s_five_fall;
    $past(rst_n_in, 2) && ce_in && $past(ce_in) && !ext_five_pin_n_in && $past(ext_five_pin_n_in);
  endsequence
  property p_doubler;
    s_wr_ctl |-> ##2 (serial1_baud_doubler_out == $past(sfr_wdata_in[7], 2));
  endproperty
  // ----------------
  // checks
  // ----------------
  a_doubler_copy: assert property (p_doubler)
    else $error("doubler differs from written bit");
  a_rsvd_ctl: assert property (s_rd ##0 (sfr_addr_in == 8'hD8) |=> sfr_rdata_out[6] && sfr_rdata_out[2:0] == 3'h0)
    else $error("control reserved bits wrong");
  a_rsvd_upper: assert property (s_rd ##0 (sfr_addr_in == 8'hE8 || sfr_addr_in == 8'hF8) |=>
    sfr_rdata_out[7:5] == 3'h7)
    else $error("enable or priority reserved bits wrong");
  a_unmapped_zero: assert property (s_rd ##0 (sfr_addr_in != 8'hD8 && sfr_addr_in != 8'hE8 && sfr_addr_in != 8'hF8)
    |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_wake_top: assert property (pending_out[5] |-> irq_req_out && irq_src_out == 3'h5 && irq_level_out == 2'h2)
    else $error("wake request not on top");
  a_src_pending: assert property (irq_req_out |-> pending_out[irq_src_out])
    else $error("selected source not pending");
  a_idle_none: assert property (!irq_req_out |-> irq_src_out == 3'h7 && pending_out == 6'h00)
    else $error("idle request state wrong");
  a_global_mask: assert property (!global_enable_in [*3] |-> pending_out[4:0] == 5'h00)
    else $error("global enable did not mask");
  a_usb_gate: assert property (pending_out[0] |-> $past(usb_irq_flag_in) || $past(usb_irq_flag_in, 2))
    else $error("usb pending without flag");
  a_twowire_gate: assert property (pending_out[1] |-> $past(twowire_irq_flag_in) || $past(twowire_irq_flag_in, 2))
    else $error("two-wire pending without flag");
  a_four_pulse: assert property (s_four_rise |-> ##[1:3] ext_four_set_out)
    else $error("pin four edge gave no pulse");
  a_five_pulse: assert property (s_five_fall |-> ##[1:3] ext_five_set_out)
    else $error("pin five edge gave no pulse");
endmodule : eir_ext_irq_monitor

bind eir_ext_irq eir_ext_irq_monitor u_mon (.*);

//--- dv/tb_eir_ext_irq.sv
`timescale 1ns/1ps
module tb_eir_ext_irq;
  logic clk_in, rst_n_in, ce_in, sfr_wr_in, sfr_rd_in, wake_pin_in, second_wake_pin_in, usb_resume_in;
  logic ext_six_pin_in, ext_four_pin_in, ext_five_pin_n_in, waveform_engine_irq_in, global_enable_in;
  logic usb_irq_flag_in, twowire_irq_flag_in, ext_four_request_in, ext_five_request_in;
  logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, m_ctl;
  logic ext_four_set_out, ext_five_set_out, serial1_baud_doubler_out, irq_req_out;
  logic [5:0] pending_out;
  logic [2:0] irq_src_out;
  logic [1:0] irq_level_out;
  logic [4:0] m_en, m_pr;
  logic [31:0] r;
  logic [7:0] addrs [4] = '{8'hD8, 8'hE8, 8'hF8, 8'h90};
  int err_total, checks_done, n4, n5;

  eir_ext_irq uut (.*);

  // 40 MHz
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // set pulses are one cycle, so a per-edge count is exact
  always @(posedge clk_in) begin
    n4 += ext_four_set_out;
    n5 += ext_five_set_out;
  end

  // ----------------
  // model and checks
  // ----------------
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  function automatic logic [7:0] rexp(logic [7:0] a);
    case (a)
      eir_pkg::ADDR_CONTROL: return m_ctl | 8'h40;
      eir_pkg::ADDR_ENABLE: return {3'h7, m_en};
      eir_pkg::ADDR_PRIORITY: return {3'h7, m_pr};
      default: return 8'h00;
    endcase
  endfunction : rexp

  // wake first, then high level, then low level; lowest slot wins a tie
  task automatic chk_irq();
    logic [5:0] p;
    int s;
    p[4:0] = {m_ctl[3], ext_five_request_in, ext_four_request_in, twowire_irq_flag_in, usb_irq_flag_in};
    p[4:0] = p[4:0] & m_en & {5{global_enable_in}};
    p[5] = m_ctl[5] & m_ctl[4];
    s = 7;
    for (int i = 4; i >= 0; i--) if (p[i] && !m_pr[i]) s = i;
    for (int i = 4; i >= 0; i--) if (p[i] && m_pr[i]) s = i;
    if (p[5]) s = 5;
    chk("pending", 8'(p), 8'(pending_out));
    chk("source", 8'(s), 8'(irq_src_out));
    chk("request", 8'(p != 0), 8'(irq_req_out));
    if (p != 0) chk("level", p[5] ? 8'h02 : 8'(m_pr[s]), 8'(irq_level_out));
    chk("doubler", 8'(m_ctl[7]), 8'(serial1_baud_doubler_out));
  endtask : chk_irq

  task automatic settle();
    repeat (3) @(negedge clk_in);
    chk_irq();
  endtask : settle

  // ----------------
  // register bus
  // ----------------
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'b1;
    if (ce_in && a == eir_pkg::ADDR_CONTROL) m_ctl = d & 8'hB8;
    if (ce_in && a == eir_pkg::ADDR_ENABLE) m_en = d[4:0];
    if (ce_in && a == eir_pkg::ADDR_PRIORITY) m_pr = d[4:0];
    @(negedge clk_in);
    sfr_wr_in = 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a);
    @(negedge clk_in);
    sfr_addr_in = a;
    sfr_rd_in = 1'b1;
    @(negedge clk_in);
    sfr_rd_in = 1'b0;
    @(negedge clk_in);
    chk("rdata", rexp(a), sfr_rdata_out);
  endtask : rd

  task automatic wait_req();
    int i;
    for (i = 0; i < 8 && irq_req_out !== 1'b1; i++) @(negedge clk_in);
    if (i == 8) begin
      err_total++;
      $display("[ERR] irq_req_out exp 1 got %b", irq_req_out);
      end_of_test();
    end
  endtask : wait_req

  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ----------------
  // main sequence
  // ----------------
  initial begin
    {rst_n_in, ce_in, sfr_wr_in, sfr_rd_in, wake_pin_in, second_wake_pin_in, usb_resume_in} = '0;
    {ext_six_pin_in, ext_four_pin_in, waveform_engine_irq_in, global_enable_in} = '0;
    {usb_irq_flag_in, twowire_irq_flag_in, ext_four_request_in, ext_five_request_in} = '0;
    ext_five_pin_n_in = 1'b1;
    {sfr_addr_in, sfr_wdata_in, m_ctl, m_en, m_pr} = '0;
    void'($urandom(32'h82FB));
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    ce_in = 1'b1;
    foreach (addrs[i]) rd(addrs[i]);
    // a write with the clock enable low must leave no trace
    ce_in = 1'b0;
    wr(eir_pkg::ADDR_ENABLE, 8'h1F);
    ce_in = 1'b1;
    rd(eir_pkg::ADDR_ENABLE);
    for (int k = 0; k < 3; k++) begin
      foreach (addrs[i]) wr(addrs[i], 8'($urandom));
      foreach (addrs[i]) rd(addrs[i]);
      settle();
    end
    wr(eir_pkg::ADDR_CONTROL, 8'h10);
    settle();
    wr(eir_pkg::ADDR_CONTROL, 8'h30);
    repeat (3) settle();
    wr(eir_pkg::ADDR_CONTROL, 8'h20);
    settle();
    for (int k = 0; k < 3; k++) begin
      @(negedge clk_in);
      wake_pin_in = (k == 0);
      second_wake_pin_in = (k == 1);
      usb_resume_in = (k == 2);
      m_ctl[4] = 1'b1;
      @(negedge clk_in);
      usb_resume_in = 1'b0;
      wait_req();
      settle();
      wake_pin_in = 1'b0;
      second_wake_pin_in = 1'b0;
      wr(eir_pkg::ADDR_CONTROL, 8'h20);
    end
    global_enable_in = 1'b1;
    wr(eir_pkg::ADDR_ENABLE, 8'h10);
    ext_six_pin_in = 1'b1;
    m_ctl[3] = 1'b1;
    settle();
    ext_six_pin_in = 1'b0;
    settle();
    wr(eir_pkg::ADDR_ENABLE, 8'h00);
    settle();
    wr(eir_pkg::ADDR_CONTROL, 8'h20);
    wr(eir_pkg::ADDR_CONTROL, 8'h28);
    wr(eir_pkg::ADDR_ENABLE, 8'h10);
    settle();
    for (int k = 0; k < 40; k++) begin
      r = $urandom;
      wr(eir_pkg::ADDR_ENABLE, r[7:0]);
      wr(eir_pkg::ADDR_PRIORITY, r[15:8]);
      wr(eir_pkg::ADDR_CONTROL, r[23:16]);
      {usb_irq_flag_in, twowire_irq_flag_in, ext_four_request_in, ext_five_request_in} = r[27:24];
      global_enable_in = r[28] | r[29];
      settle();
    end
    for (int k = 0; k < 3; k++) begin
      n4 = 0;
      n5 = 0;
      ext_four_pin_in = (k == 0);
      waveform_engine_irq_in = (k == 1);
      ext_five_pin_n_in = (k != 2);
      repeat (4) @(negedge clk_in);
      {ext_four_pin_in, waveform_engine_irq_in, ext_five_pin_n_in} = 3'h1;
      repeat (4) @(negedge clk_in);
      chk("four_set", 8'(k < 2), 8'(n4));
      chk("five_set", 8'(k == 2), 8'(n5));
    end
    end_of_test();
  end
endmodule : tb_eir_ext_irq
